//--- src/sleep_wake_ctrl.sv
`timescale 1ns/1ps
`include "sleep_wake_consts.svh"
module sleep_wake_ctrl #(
  parameter int N_AIN = 2,
  parameter int W     = 16
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [N_AIN*W-1:0]    ain_cal,
  input  wire sleep_wake_pkg::cmd_s  cmd_pin,
  output logic                       run_permit,
  output logic                       ain_loss,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  initial begin
    if (N_AIN < 1 || N_AIN > 16 || W != 16) $error("unsupported sleep_wake_ctrl parameters");
  end
  localparam int TICKS = `SW_TICK_CYCLES;

  // pins cross in through two flops
  sleep_wake_pkg::cmd_s       cmd_s1, cmd;
  logic [N_AIN*W-1:0]         ain_s1, ain;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_s1 <= '0;
      cmd    <= '0;
      ain_s1 <= '0;
      ain    <= '0;
    end else begin
      cmd_s1 <= cmd_pin;
      cmd    <= cmd_s1;
      ain_s1 <= ain_cal;
      ain    <= ain_s1;
    end
  end

  // registers
  logic          mode_direct;
  logic [3:0]    src_sel;
  logic [W-1:0]  wake_level, sleep_level, wake_time, sleep_time;

  // control tick
  logic [15:0] tick_cnt;
  logic        tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 16'(TICKS - 1));
      tick_cnt <= (tick_cnt == 16'(TICKS - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  // select source, absolute of calibrated value
  function automatic logic [W-1:0] absval(input logic [W-1:0] v);
    absval = v[W-1] ? W'(-v) : v;
  endfunction : absval
  logic [W-1:0] sel_raw, mag;
  assign sel_raw = (src_sel < 4'(N_AIN)) ? ain[src_sel*W +: W] : '0;
  assign mag     = absval(sel_raw);

  wire wake_cond  = (mag >= wake_level);
  wire sleep_cond = (mag <= sleep_level);
  wire crossed    = (wake_level < sleep_level);

  // timers start at zero, i.e. asleep
  logic          wake_edge, sleep_edge;
  logic [W-1:0]  wake_cnt, sleep_cnt;
  qual_timer #(.W(W)) u_wake (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tick       (tick),
    .cond       (wake_cond),
    .limit      (wake_time),
    .done_pulse (wake_edge),
    .count      (wake_cnt)
  );
  qual_timer #(.W(W)) u_sleep (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tick       (tick),
    .cond       (sleep_cond),
    .limit      (sleep_time),
    .done_pulse (sleep_edge),
    .count      (sleep_cnt)
  );
  wire sleep_expired = (sleep_cnt >= sleep_time);

  // state toggles on edges; sleep wins a tie
  logic awake, blocked;
  sleep_wake_pkg::restart_e reason;
  logic run_prev;
  wire  run_rise = cmd.run & ~run_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awake    <= 1'b0;
      run_prev <= 1'b0;
    end else begin
      run_prev <= cmd.run;
      if (sleep_edge) awake <= 1'b0;
      else if (wake_edge) awake <= 1'b1;
    end
  end

  wire permissive = cmd.stop_n & cmd.enable & ~cmd.fault & ~cmd.alarm;
  // a held enable or run input is the maintained start
  wire held_input = cmd.enable | cmd.run;
  // restart after stop needs a new command or run edge; after fault with run held, only a new run edge
  wire need_new   = (reason == sleep_wake_pkg::REASON_FAULT_RUN) ? ~run_rise :
                    (reason == sleep_wake_pkg::REASON_STOP) ? ~(cmd.new_cmd | run_rise) : 1'b0;
  // after a stop, above sleep level suffices
  wire sig_ok     = (reason == sleep_wake_pkg::REASON_STOP) ? ~sleep_cond : awake;

  // crossed levels block only a restart, not a running drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blocked <= 1'b0;
      reason  <= sleep_wake_pkg::REASON_NONE;
    end else begin
      if (!crossed) blocked <= 1'b0;
      else if (sleep_edge) blocked <= 1'b1;
      if (cmd.fault && cmd.run) reason <= sleep_wake_pkg::REASON_FAULT_RUN;
      else if (!cmd.stop_n && run_permit) reason <= sleep_wake_pkg::REASON_STOP;
      else if (run_permit) reason <= sleep_wake_pkg::REASON_NONE;
    end
  end

  // bypass by jog or local control
  wire bypass   = cmd.jog | cmd.local_any;
  // separate starts only while sleep timer unexpired
  wire sep_ok   = cmd.start & ~sleep_expired & ~cmd.fault & cmd.stop_n;
  // levels read live each cycle, no clamp
  wire can_start = sig_ok & ~need_new & ~(crossed | blocked);
  // combination evaluated continuously after reset and mode change
  wire sw_run   = permissive & held_input & (run_permit ? ~sleep_expired | awake : can_start);
  wire next_run = bypass ? ((cmd.start | cmd.run | cmd.jog) & ~cmd.fault) :
                  mode_direct ? (sw_run | (sep_ok & ~awake & permissive)) :
                  (permissive & (cmd.start | cmd.run));
  // loss detection on the selected magnitude, not on the levels
  wire next_loss = (mag < `SW_LOSS_LEVEL);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_permit <= 1'b0;
      ain_loss   <= 1'b0;
    end else begin
      run_permit <= next_run;
      ain_loss   <= next_loss;
    end
  end

  // axi4-lite slave, one transaction per channel pair
  logic aw_hold, w_hold;
  logic [31:0] aw_addr, w_data;
  wire  do_write = aw_hold & w_hold & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      mode_direct   <= 1'b0;
      src_sel       <= '0;
      wake_level    <= `SW_LEVEL_RESET;
      sleep_level   <= `SW_LEVEL_RESET;
      wake_time     <= `SW_TIME_RESET;
      sleep_time    <= `SW_TIME_RESET;
    end else begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `AXI_OKAY;
        // an unmapped upper address must not alias onto a register
        if (aw_addr[31:8] != 24'h000000) begin
          s_axi_bresp <= `AXI_SLVERR;
        end else begin
          case (aw_addr[7:0])
            `SW_REG_CTRL: begin
              mode_direct <= w_data[`SW_CTRL_MODE_BIT];
              src_sel     <= w_data[`SW_CTRL_SRC_LSB +: 4];
            end
            `SW_REG_WAKE_LEVEL: wake_level <= w_data[W-1:0];
            `SW_REG_SLEEP_LEVEL: sleep_level <= w_data[W-1:0];
            `SW_REG_WAKE_TIME: wake_time <= w_data[W-1:0];
            `SW_REG_SLEEP_TIME: sleep_time <= w_data[W-1:0];
            `SW_REG_STATUS: s_axi_bresp <= `AXI_OKAY;
            default: s_axi_bresp <= `AXI_SLVERR;
          endcase
        end
      end
    end
  end

  logic [31:0] rd_word;
  logic        rd_ok;
  wire  [31:0] status_word = {25'h0, sleep_expired, (wake_cnt >= wake_time), ain_loss,
                              blocked, crossed, awake, run_permit};
  always_comb begin
    rd_ok = (s_axi_araddr[31:8] == 24'h000000);
    case (s_axi_araddr[7:0])
      `SW_REG_CTRL:        rd_word = {24'h0, src_sel, 3'h0, mode_direct};
      `SW_REG_WAKE_LEVEL:  rd_word = {16'h0, wake_level};
      `SW_REG_SLEEP_LEVEL: rd_word = {16'h0, sleep_level};
      `SW_REG_WAKE_TIME:   rd_word = {16'h0, wake_time};
      `SW_REG_SLEEP_TIME:  rd_word = {16'h0, sleep_time};
      `SW_REG_STATUS:      rd_word = status_word;
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  a_sleep_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_direct && !bypass && sleep_expired && !awake && !run_permit) |=> !run_permit)
    else $error("started while sleep timer expired");
  a_edge_sets_awake: assert property (@(posedge aclk) disable iff (!aresetn)
    (wake_edge && !sleep_edge) |=> awake)
    else $error("wake edge did not set awake");
  a_sleep_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_edge |=> !awake)
    else $error("sleep edge did not clear awake");
  a_fault_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd.fault && mode_direct && !bypass) |=> !run_permit)
    else $error("run permitted during fault");
  a_cross_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    (crossed && !run_permit && mode_direct && !bypass && !sep_ok) |=> !run_permit)
    else $error("started with crossed levels");
  a_timer_sat: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && wake_cnt == '0 && !wake_cond) |=> wake_cnt == '0)
    else $error("wake timer wrapped below zero");
  a_timer_up: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && wake_cond && wake_cnt < wake_time) |=> wake_cnt == $past(wake_cnt) + W'(1))
    else $error("wake timer did not count up");
  a_jog_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd.jog && !cmd.fault) |=> run_permit)
    else $error("jog did not bypass sleep");
endmodule : sleep_wake_ctrl

//--- src/sleep_wake_consts.svh
// Overview of operation
// - analog magnitude at or above wake level counts as the wake condition.
// - analog magnitude at or below sleep level counts as the sleep condition.
// - function acts only when the mode selector is set to direct.
// - wake start needs no stop, enable present, no fault, no alarm.
// - each qualification timer counts up while satisfied, down while not.
// - timer reaching its time gives one edge toggling sleep or wake state.
// - after reset timers sit in the no-start state until a level is met.
// - other start commands honored only while sleep timer has not expired.
// - jog or any local-control port bypasses the sleep and wake function.
// - the local port, port 0 included, may run the drive while asleep.
// - no start while wake level is below sleep level; no clamping; code still honors a separate start while sleep timer unexpired.
// - both levels writable while running, taking effect without a stop.
// - crossed levels while running keep running until sleep, then block restart.
// - any analog input selectable as source, shared use unaffected.
// - compare absolute calibrated value, ignoring user scaling high and low.
// - analog loss detection runs independent of the levels.
// - after reset the drive starts if all start conditions hold.
// - enabling the function with all conditions met starts immediately.
// - new start or run commands come only from panel, terminals or network.
// - with run inputs after fault reset or stop, run must be cycled plus wake; after a stop code takes run edge or new command, signal over sleep level.
// - after a stop, a new start restarts once signal exceeds sleep level.
`ifndef SLEEP_WAKE_CONSTS_SVH
`define SLEEP_WAKE_CONSTS_SVH
`define SW_REG_CTRL        32'h0000_0000
`define SW_REG_WAKE_LEVEL  32'h0000_0004
`define SW_REG_SLEEP_LEVEL 32'h0000_0008
`define SW_REG_WAKE_TIME   32'h0000_000c
`define SW_REG_SLEEP_TIME  32'h0000_0010
`define SW_REG_STATUS      32'h0000_0014
`define SW_CTRL_MODE_BIT   0
`define SW_CTRL_SRC_LSB    4
`define SW_ST_RUN_BIT      0
`define SW_ST_AWAKE_BIT    1
`define SW_ST_CROSS_BIT    2
`define SW_ST_BLOCK_BIT    3
`define SW_ST_LOSS_BIT     4
`define SW_ST_WTMR_BIT     5
`define SW_ST_STMR_BIT     6
`define SW_TICK_NS         1000
`define SW_CLK_NS          40
`define SW_TICK_CYCLES     (`SW_TICK_NS / `SW_CLK_NS)
`define SW_LOSS_LEVEL      16'h0100
`define SW_LEVEL_RESET     16'h0000
`define SW_TIME_RESET      16'h000a
`define AXI_OKAY           2'b00
`define AXI_SLVERR         2'b10
`endif

//--- src/sleep_wake_pkg.sv
package sleep_wake_pkg;
  typedef struct packed {
    logic stop_n;
    logic enable;
    logic fault;
    logic alarm;
    logic start;
    logic run;
    logic jog;
    logic local_any;
    logic new_cmd;
  } cmd_s;
  typedef enum logic [1:0] {
    REASON_NONE,
    REASON_STOP,
    REASON_FAULT_RUN
  } restart_e;
endpackage : sleep_wake_pkg

//--- src/qual_timer.sv
`timescale 1ns/1ps
module qual_timer #(
  parameter int W = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              done_pulse,
  output logic [W-1:0]      count
);
  initial begin
    if (W < 2) $error("qual_timer width too small");
  end
  logic at_max;
  logic at_min;
  assign at_max = (count >= limit);
  assign at_min = (count == '0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count      <= '0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (tick) begin
        if (cond && !at_max) begin
          count <= count + W'(1);
          if (count + W'(1) >= limit) done_pulse <= 1'b1;
        end else if (!cond && !at_min) begin
          count <= count - W'(1);
        end
      end
    end
  end
endmodule : qual_timer

//--- tb/sensor_operator_model.sv
`timescale 1ns/1ps
module sensor_operator_model (
  input  wire logic                 aclk,
  input  wire logic [31:0]          set_ain,
  input  wire sleep_wake_pkg::cmd_s set_cmd,
  output logic [31:0]               ain_cal,
  output sleep_wake_pkg::cmd_s      cmd_pin
);
  // levels only change on a clock edge, like a sampled terminal
  initial begin
    ain_cal = 32'h0;
    cmd_pin = 9'h180;
  end
  // commands as set by the operator, passed on at each clock
  always @(posedge aclk) begin
    ain_cal <= set_ain;
    cmd_pin <= set_cmd;
  end
endmodule : sensor_operator_model

//--- tb/sleep_wake_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "sleep_wake_consts.svh"
module sleep_wake_ctrl_tb_top;
  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  logic [31:0]          set_ain = 32'h0;
  sleep_wake_pkg::cmd_s set_cmd = 9'h180;
  logic [31:0]          ain_cal;
  sleep_wake_pkg::cmd_s cmd_pin;
  logic                 run_permit;
  logic                 ain_loss;
  logic [31:0]          awaddr = 32'h0;
  logic [31:0]          wdata = 32'h0;
  logic [31:0]          araddr = 32'h0;
  logic                 awvalid = 1'b0;
  logic                 wvalid = 1'b0;
  logic                 bready = 1'b0;
  logic                 arvalid = 1'b0;
  logic                 rready = 1'b0;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [1:0]           bresp, rresp, rs;
  logic [31:0]          rdata, rd;
  int                   n_errors = 0;
  int                   n_checks = 0;
  int                   cyc = 0;

  always #20 aclk = ~aclk;

  sensor_operator_model sensor_operator_model_inst (
    .aclk(aclk), .set_ain(set_ain), .set_cmd(set_cmd), .ain_cal(ain_cal), .cmd_pin(cmd_pin));

  sleep_wake_ctrl #(.N_AIN(2), .W(16)) sleep_wake_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .ain_cal(ain_cal), .cmd_pin(cmd_pin),
    .run_permit(run_permit), .ain_loss(ain_loss),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // both channels offered together, each released on its own handshake
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic drive_ain(input logic [31:0] v);
    @(posedge aclk);
    set_ain <= v;
  endtask : drive_ain

  task automatic wait_run(input logic e, input int lim);
    int i;
    i = 0;
    while (run_permit !== e && i < lim) begin
      @(posedge aclk);
      i++;
    end
    chk("run_permit", 32'(e), 32'(run_permit));
  endtask : wait_run

  // run_permit must stay at e for all n cycles; only n of 20 is shorter than two ticks of qualification
  task automatic hold_run(input logic e, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge aclk);
      if (run_permit !== e) bad = 1;
    end
    chk("run_permit steady", 32'h0, bad);
  endtask : hold_run

  task automatic t_regs;
    axi_rd(`SW_REG_CTRL);
    chk("ctrl", 32'h0, rd);
    chk("rresp", 32'(`AXI_OKAY), 32'(rs));
    axi_rd(`SW_REG_WAKE_TIME);
    chk("wake time", 32'h0000_000a, rd);
    axi_rd(32'h0000_0018);
    chk("rresp", 32'(`AXI_SLVERR), 32'(rs));
    chk("rdata", 32'h0, rd);
    axi_wr(32'h0000_0100, 32'h0000_00ff);
    chk("bresp", 32'(`AXI_SLVERR), 32'(rs));
    $display("test regs done");
  endtask : t_regs

  task automatic t_wake;
    drive_ain(32'h0000_0800);
    axi_wr(`SW_REG_WAKE_LEVEL, 32'h0000_4000);
    axi_wr(`SW_REG_SLEEP_LEVEL, 32'h0000_1000);
    axi_wr(`SW_REG_WAKE_TIME, 32'h0000_0002);
    axi_wr(`SW_REG_SLEEP_TIME, 32'h0000_0002);
    axi_wr(`SW_REG_CTRL, 32'h0000_0001);
    hold_run(1'b0, 150);
    drive_ain(32'h0000_5000);
    hold_run(1'b0, 20);
    wait_run(1'b1, 200);
    $display("test wake done");
  endtask : t_wake

  task automatic t_sleep;
    drive_ain(32'h0000_0800);
    hold_run(1'b1, 20);
    wait_run(1'b0, 200);
    @(posedge aclk);
    set_cmd.start <= 1'b1;
    hold_run(1'b0, 100);
    @(posedge aclk);
    set_cmd.local_any <= 1'b1;
    wait_run(1'b1, 20);
    @(posedge aclk);
    set_cmd.local_any <= 1'b0;
    set_cmd.start <= 1'b0;
    wait_run(1'b0, 20);
    @(posedge aclk);
    set_cmd.jog <= 1'b1;
    wait_run(1'b1, 20);
    @(posedge aclk);
    set_cmd.jog <= 1'b0;
    wait_run(1'b0, 20);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_fault;
    @(posedge aclk);
    set_cmd.fault <= 1'b1;
    set_ain <= 32'h0000_5000;
    hold_run(1'b0, 150);
    @(posedge aclk);
    set_cmd.fault <= 1'b0;
    set_cmd.new_cmd <= 1'b1;
    repeat (5) @(posedge aclk);
    set_cmd.new_cmd <= 1'b0;
    wait_run(1'b1, 200);
    $display("test fault done");
  endtask : t_fault

  task automatic t_cross;
    axi_wr(`SW_REG_SLEEP_LEVEL, 32'h0000_4800);
    hold_run(1'b1, 150);
    axi_rd(`SW_REG_STATUS);
    chk("crossed", 32'h1, 32'(rd[`SW_ST_CROSS_BIT]));
    drive_ain(32'h0000_3000);
    wait_run(1'b0, 200);
    drive_ain(32'h0000_5000);
    hold_run(1'b0, 150);
    axi_rd(`SW_REG_STATUS);
    chk("blocked", 32'h1, 32'(rd[`SW_ST_BLOCK_BIT]));
    axi_wr(`SW_REG_SLEEP_LEVEL, 32'h0000_1000);
    wait_run(1'b1, 200);
    $display("test cross done");
  endtask : t_cross

  task automatic t_source;
    axi_wr(`SW_REG_CTRL, 32'h0000_0011);
    drive_ain(32'h0800_5000);
    wait_run(1'b0, 200);
    drive_ain(32'hb000_0800);
    wait_run(1'b1, 200);
    drive_ain(32'hff80_5000);
    repeat (10) @(posedge aclk);
    chk("ain_loss", 32'h1, 32'(ain_loss));
    drive_ain(32'h0200_0000);
    repeat (10) @(posedge aclk);
    chk("ain_loss", 32'h0, 32'(ain_loss));
    $display("test source done");
  endtask : t_source

  task automatic t_mode;
    axi_wr(`SW_REG_CTRL, 32'h0000_0000);
    drive_ain(32'h0000_0200);
    @(posedge aclk);
    set_cmd.start <= 1'b1;
    wait_run(1'b1, 20);
    @(posedge aclk);
    set_cmd.start <= 1'b0;
    wait_run(1'b0, 20);
    $display("test mode done");
  endtask : t_mode

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_wake;
    t_sleep;
    t_fault;
    t_cross;
    t_source;
    t_mode;
    tally_and_finish;
  end
endmodule : sleep_wake_ctrl_tb_top
